// >>> rtl/drc_defines.svh
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH
// Register byte offsets
`define DRC_OFS_CTRL 8'h00
`define DRC_OFS_TRIG_MASK 8'h04
`define DRC_OFS_REC_LEN 8'h08
`define DRC_OFS_PRE_LEN 8'h0C
`define DRC_OFS_CHAN_CFG 8'h10
`define DRC_OFS_CMD 8'h14
`define DRC_OFS_CLR_IDX 8'h18
`define DRC_OFS_STATUS 8'h1C
`define DRC_OFS_MAX_NUM 8'h20
`define DRC_OFS_MAX_LEN 8'h24
`define DRC_OFS_MAX_PRE 8'h28
`define DRC_OFS_RD_IDX 8'h2C
`define DRC_OFS_REC_ID 8'h30
`define DRC_OFS_CHAN 8'h34
// Field positions
`define DRC_CTRL_EN 0
`define DRC_CTRL_KEEP 1
`define DRC_CTRL_SR_LO 2
`define DRC_CMD_MAN 0
`define DRC_CMD_CLR_ALL 1
`define DRC_CMD_CLR_NEW 2
`define DRC_CMD_CLR_OLD 3
// Reset values
`define DRC_RST_REC_LEN 32'h0000_03E8
`define DRC_RST_PRE_LEN 32'h0000_00C8
// Limits and rates
`define DRC_NREC 100
`define DRC_MAX_REC 7'h64
`define DRC_MAX_LEN_CAP 32'h001B_7740
`define DRC_RESERVE 48'h0000_00F5_4F67
`define DRC_MS_PER_S 48'h0000_0000_03E8
`define DRC_FN_HZ 32'h0000_0032
`define DRC_DIG_HZ 32'h0000_00C8
// Digital channel sampling: time in ms, rate in kHz, count derived
`define DRC_SAMPLE_MS 5
`define DRC_CLK_KHZ 200000
`define DRC_SAMPLE_CYC (`DRC_SAMPLE_MS * `DRC_CLK_KHZ)
`define DRC_DIV_STEPS 6'h30
`endif

// >>> rtl/drc_pkg.sv
package drc_pkg;
  typedef enum logic [2:0] {
    DRC_READY = 3'h0,
    DRC_TRIGGERED = 3'h1,
    DRC_REC_STORE = 3'h3,
    DRC_STORING = 3'h2,
    DRC_FULL = 3'h6,
    DRC_BAD_CFG = 3'h4
  } drc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } drc_apb_req_t;

  typedef struct packed {
    logic [25:0] ext_ch;
    logic freq_func_enabled;
    logic time_sync_lost_alarm;
    logic internal_fault;
    logic phase_order_reversed;
  } drc_chan_in_t;
endpackage : drc_pkg

// >>> rtl/drc_top.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "drc_defines.svh"
module drc_top #(
  parameter int unsigned SAMPLE_CYC = `DRC_SAMPLE_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire drc_pkg::drc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire drc_pkg::drc_chan_in_t chan_in,
  output drc_pkg::drc_state_t rec_status,
  output logic rec_start,
  output logic [6:0] stored_count
);
  import drc_pkg::*;

  localparam int NREC = `DRC_NREC;

  logic ctrl_en_reg, keep_olds_reg;
  logic [1:0] sr_code_reg;
  logic [31:0] trig_mask_reg, rec_len_reg, pre_len_reg, chan_smp_reg;
  logic [4:0] an_cnt_reg;
  logic [6:0] dig_cnt_reg, rd_idx_reg, cnt_reg, max_num_reg;
  logic [31:0] max_len_reg, max_pre_reg;
  logic manual_reg, auto_hit_reg;
  logic clr_all_p_reg, clr_new_p_reg, clr_old_p_reg, clr_idx_p_reg;
  logic [31:0] clr_idx_reg;
  drc_state_t st_reg, st_next;
  logic [19:0] tick_cnt_reg;
  logic tick;
  logic [31:0] post_ms_reg;
  logic [15:0] seq_reg;
  logic [15:0] rec_id_mem [NREC];

  logic acc, wr_en;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr_en = acc && pready && apb_req.pwrite;

  // Binary channel vector: bit 0 constant low, bit 1 constant high
  logic [31:0] chan_now;
  assign chan_now = {chan_in.ext_ch, chan_in.freq_func_enabled,
                     chan_in.time_sync_lost_alarm, chan_in.internal_fault,
                     chan_in.phase_order_reversed, 1'b1, 1'b0};

  // 5 ms sampling divider
  always_ff @(posedge clk_sys) begin
    if (sys_rst || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 20'h0_0001;
    end
  end
  assign tick = (tick_cnt_reg == 20'(SAMPLE_CYC - 1));

  // Only rising edges between samples trigger, so a stuck-high source fires once
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chan_smp_reg <= '0;
      auto_hit_reg <= 1'b0;
    end else begin
      auto_hit_reg <= tick && |(chan_now & ~chan_smp_reg & trig_mask_reg);
      if (tick) begin
        chan_smp_reg <= chan_now;
      end
    end
  end

  // Derived figures, recomputed continuously; max length and max number by one shared serial divider
  logic [31:0] rate, sr_val;
  assign sr_val = 32'h0000_0040 >> sr_code_reg;
  assign rate = `DRC_FN_HZ * ({27'h0, an_cnt_reg} + 32'h0000_0001) * sr_val
              + `DRC_DIG_HZ * {25'h0, dig_cnt_reg};

  logic div_ph_reg;
  logic [5:0] div_step_reg;
  logic [47:0] div_q_reg;
  logic [32:0] div_rem_reg, rem_sh;
  logic [31:0] divisor;
  logic rem_ge;
  assign divisor = div_ph_reg ? rec_len_reg : rate;
  assign rem_sh = {div_rem_reg[31:0], div_q_reg[47]};
  assign rem_ge = rem_sh >= {1'b0, divisor};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_ph_reg <= 1'b0;
      div_step_reg <= '0;
      div_q_reg <= '0;
      div_rem_reg <= '0;
      max_len_reg <= '0;
      max_num_reg <= '0;
    end else if (div_step_reg == 6'h00) begin
      div_rem_reg <= '0;
      div_q_reg <= div_ph_reg ? {16'h0000, max_len_reg} : `DRC_RESERVE * `DRC_MS_PER_S;
      div_step_reg <= 6'h01;
    end else begin
      div_rem_reg <= rem_ge ? rem_sh - {1'b0, divisor} : rem_sh;
      div_q_reg <= {div_q_reg[46:0], rem_ge};
      if (div_step_reg == `DRC_DIV_STEPS) begin
        div_step_reg <= '0;
        div_ph_reg <= ~div_ph_reg;
        if (!div_ph_reg) begin
          max_len_reg <= ({div_q_reg[46:0], rem_ge} > {16'h0000, `DRC_MAX_LEN_CAP}) ?
                         `DRC_MAX_LEN_CAP : {div_q_reg[30:0], rem_ge};
        end else begin
          max_num_reg <= ({div_q_reg[46:0], rem_ge} > {41'h0, `DRC_MAX_REC}) ?
                         `DRC_MAX_REC : {div_q_reg[5:0], rem_ge};
        end
      end else begin
        div_step_reg <= div_step_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      max_pre_reg <= '0;
    end else begin
      max_pre_reg <= (max_len_reg < rec_len_reg) ? max_len_reg : rec_len_reg;
    end
  end

  // Recorder state machine
  logic cfg_ok, trig_go, mem_full, store;
  assign cfg_ok = (trig_mask_reg != '0) && (max_len_reg != '0)
               && (max_num_reg != '0);
  assign trig_go = ctrl_en_reg && (manual_reg || auto_hit_reg);
  assign mem_full = (cnt_reg >= max_num_reg);
  assign store = (st_reg == DRC_STORING) && tick;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      DRC_READY: begin
        if (trig_go) begin
          st_next = DRC_TRIGGERED;
        end
      end
      DRC_TRIGGERED: begin
        if (tick) begin
          st_next = DRC_REC_STORE;
        end
      end
      DRC_REC_STORE: begin
        if (tick && post_ms_reg + 32'h0000_0005 + pre_len_reg >= rec_len_reg) begin
          st_next = DRC_STORING;
        end
      end
      DRC_STORING: begin
        if (tick) begin
          st_next = DRC_READY;
        end
      end
      DRC_FULL: begin
        if (!mem_full || !keep_olds_reg) begin
          st_next = DRC_READY;
        end
      end
      DRC_BAD_CFG: begin
        st_next = DRC_READY;
      end
      default: begin
        st_next = DRC_READY;
      end
    endcase
    if (!cfg_ok) begin
      st_next = DRC_BAD_CFG;
    end else if (!ctrl_en_reg) begin
      st_next = DRC_READY;
    end else if (keep_olds_reg && mem_full && st_next == DRC_READY) begin
      st_next = DRC_FULL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= DRC_BAD_CFG;
      post_ms_reg <= '0;
      rec_start <= 1'b0;
    end else begin
      st_reg <= st_next;
      rec_start <= (st_reg == DRC_READY) && (st_next == DRC_TRIGGERED);
      if (st_reg != DRC_REC_STORE) begin
        post_ms_reg <= '0;
      end else if (tick) begin
        post_ms_reg <= post_ms_reg + 32'h0000_0005;
      end
    end
  end

  // Record list: entry 0 is the oldest; a delete shifts later entries down
  logic op_del, op_push;
  logic [6:0] del_k, push_pos;
  logic do_clr_all, do_clr_new, do_clr_old, do_clr_idx, idx_ok;
  assign idx_ok = (clr_idx_reg != '0) && (clr_idx_reg <= {25'h0, cnt_reg});
  // A store takes the cycle; pending clears wait one cycle behind it
  assign do_clr_all = !store && clr_all_p_reg;
  assign do_clr_idx = !store && !clr_all_p_reg && clr_idx_p_reg && idx_ok;
  assign do_clr_new = !store && !clr_all_p_reg && !clr_idx_p_reg && clr_new_p_reg
                   && cnt_reg != '0;
  assign do_clr_old = !store && !clr_all_p_reg && !clr_idx_p_reg && !clr_new_p_reg
                   && clr_old_p_reg && cnt_reg != '0;
  assign op_push = store && !(mem_full && keep_olds_reg);
  assign op_del = do_clr_idx || do_clr_old || (op_push && mem_full);
  assign del_k = do_clr_idx ? 7'(clr_idx_reg - 32'h0000_0001) : 7'h00;
  assign push_pos = op_del ? cnt_reg - 7'h01 : cnt_reg;

  for (genvar i = 0; i < NREC; i++) begin : g_rec
    logic [15:0] src;
    if (i == NREC - 1) begin : g_last
      assign src = (op_del && del_k <= 7'(i)) ? 16'h0000 : rec_id_mem[i];
    end else begin : g_mid
      assign src = (op_del && del_k <= 7'(i)) ? rec_id_mem[i + 1] : rec_id_mem[i];
    end
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        rec_id_mem[i] <= '0;
      end else begin
        rec_id_mem[i] <= (op_push && push_pos == 7'(i)) ? seq_reg : src;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      seq_reg <= '0;
    end else begin
      if (op_push) begin
        seq_reg <= seq_reg + 16'h0001;
      end
      if (do_clr_all) begin
        cnt_reg <= '0;
      end else if (op_push && !mem_full && cnt_reg < `DRC_MAX_REC) begin
        cnt_reg <= cnt_reg + 7'h01;
      end else if (do_clr_idx || do_clr_new || do_clr_old) begin
        cnt_reg <= cnt_reg - 7'h01;
      end
    end
  end

  // APB slave: one wait state, write lands on the pready edge
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    unique case (apb_req.paddr)
      `DRC_OFS_CTRL: rd_val = {28'h0, sr_code_reg, keep_olds_reg, ctrl_en_reg};
      `DRC_OFS_TRIG_MASK: rd_val = trig_mask_reg;
      `DRC_OFS_REC_LEN: rd_val = rec_len_reg;
      `DRC_OFS_PRE_LEN: rd_val = pre_len_reg;
      `DRC_OFS_CHAN_CFG: rd_val = {17'h0, dig_cnt_reg, 3'h0, an_cnt_reg};
      `DRC_OFS_CMD: rd_val = {31'h0, manual_reg};
      `DRC_OFS_CLR_IDX: rd_val = clr_idx_reg;
      `DRC_OFS_STATUS: rd_val = {17'h0, cnt_reg, 5'h0, st_reg};
      `DRC_OFS_MAX_NUM: rd_val = {25'h0, max_num_reg};
      `DRC_OFS_MAX_LEN: rd_val = max_len_reg;
      `DRC_OFS_MAX_PRE: rd_val = max_pre_reg;
      `DRC_OFS_RD_IDX: rd_val = {25'h0, rd_idx_reg};
      `DRC_OFS_REC_ID: rd_val = (rd_idx_reg < 7'(NREC)) ? {16'h0, rec_id_mem[rd_idx_reg]} : '0;
      `DRC_OFS_CHAN: rd_val = chan_smp_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !apb_req.pwrite && rd_ok) ? rd_val : '0;
      pslverr <= acc && !pready && !rd_ok;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_en_reg <= 1'b0;
      keep_olds_reg <= 1'b0;
      sr_code_reg <= '0;
      trig_mask_reg <= '0;
      rec_len_reg <= `DRC_RST_REC_LEN;
      pre_len_reg <= `DRC_RST_PRE_LEN;
      an_cnt_reg <= '0;
      dig_cnt_reg <= '0;
      rd_idx_reg <= '0;
    end else if (wr_en) begin
      unique case (apb_req.paddr)
        `DRC_OFS_CTRL: begin
          ctrl_en_reg <= apb_req.pwdata[`DRC_CTRL_EN];
          keep_olds_reg <= apb_req.pwdata[`DRC_CTRL_KEEP];
          sr_code_reg <= apb_req.pwdata[`DRC_CTRL_SR_LO +: 2];
        end
        `DRC_OFS_TRIG_MASK: trig_mask_reg <= apb_req.pwdata;
        `DRC_OFS_REC_LEN: rec_len_reg <= apb_req.pwdata;
        `DRC_OFS_PRE_LEN: pre_len_reg <= apb_req.pwdata;
        `DRC_OFS_CHAN_CFG: begin
          an_cnt_reg <= apb_req.pwdata[4:0];
          dig_cnt_reg <= apb_req.pwdata[14:8];
        end
        `DRC_OFS_RD_IDX: rd_idx_reg <= apb_req.pwdata[6:0];
        default: begin
        end
      endcase
    end
  end

  // Command pulses; a newly written command wins over its own completion
  logic cmd_wr, idx_wr;
  assign cmd_wr = wr_en && apb_req.paddr == `DRC_OFS_CMD;
  assign idx_wr = wr_en && apb_req.paddr == `DRC_OFS_CLR_IDX;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      manual_reg <= 1'b0;
      clr_all_p_reg <= 1'b0;
      clr_new_p_reg <= 1'b0;
      clr_old_p_reg <= 1'b0;
      clr_idx_p_reg <= 1'b0;
      clr_idx_reg <= '0;
    end else begin
      manual_reg <= cmd_wr && apb_req.pwdata[`DRC_CMD_MAN];
      clr_all_p_reg <= (cmd_wr && apb_req.pwdata[`DRC_CMD_CLR_ALL])
                    || (clr_all_p_reg && store);
      clr_new_p_reg <= (cmd_wr && apb_req.pwdata[`DRC_CMD_CLR_NEW])
                    || (clr_new_p_reg && (store || clr_all_p_reg || clr_idx_p_reg));
      clr_old_p_reg <= (cmd_wr && apb_req.pwdata[`DRC_CMD_CLR_OLD])
                    || (clr_old_p_reg && (store || clr_all_p_reg || clr_idx_p_reg
                        || clr_new_p_reg));
      clr_idx_p_reg <= idx_wr || (clr_idx_p_reg && (store || clr_all_p_reg));
      if (idx_wr) begin
        clr_idx_reg <= apb_req.pwdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rec_status <= DRC_BAD_CFG;
      stored_count <= '0;
    end else begin
      rec_status <= st_reg;
      stored_count <= cnt_reg;
    end
  end

  count_max_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cnt_reg <= `DRC_MAX_REC) else $error("stored count above limit");
  manual_self_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    manual_reg |=> !manual_reg) else $error("manual trigger not returned to idle");
  disabled_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctrl_en_reg |=> st_reg inside {DRC_READY, DRC_BAD_CFG}) else $error("recording while off");
  clear_all_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    do_clr_all |=> cnt_reg == 7'h00) else $error("clear all left recordings");
  clr_newest_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    do_clr_new |=> cnt_reg == $past(cnt_reg) - 7'h01) else $error("clear newest count wrong");
  bad_cfg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cfg_ok |=> st_reg == DRC_BAD_CFG) else $error("ready without valid config");
  sample_tick_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !tick |=> $stable(chan_smp_reg)) else $error("channel sampled off the tick");
  trig_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_reg == DRC_READY && trig_go && cfg_ok && !(keep_olds_reg && mem_full))
    |=> st_reg == DRC_TRIGGERED && rec_start) else $error("trigger did not start");
  null_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clr_idx_p_reg && !idx_ok && !store && !clr_all_p_reg) |=> $stable(cnt_reg))
    else $error("invalid clear changed store");
  store_c: cover property (@(posedge clk_sys) disable iff (sys_rst) op_push);
  overwrite_c: cover property (@(posedge clk_sys) disable iff (sys_rst) op_push && op_del);
  idx_clear_c: cover property (@(posedge clk_sys) disable iff (sys_rst) do_clr_idx);
endmodule : drc_top

// >>> dv/drc_tb.sv
`timescale 1ns/100ps
`include "drc_defines.svh"
module testbench;
  import drc_pkg::*;
  // Short sample period keeps the hundred-recording fill within a few thousand cycles
  localparam int unsigned SC = 20;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  drc_apb_req_t apb_req = '0;
  drc_chan_in_t chan_in = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  drc_state_t rec_status;
  logic rec_start;
  logic [6:0] stored_count;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] seen = '0;
  logic [15:0] ids[$];
  logic [15:0] nid = '0;
  logic [31:0] rv;
  logic er;

  drc_top #(.SAMPLE_CYC(SC)) DUT (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .apb_req(apb_req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .chan_in(chan_in),
    .rec_status(rec_status),
    .rec_start(rec_start),
    .stored_count(stored_count)
  );

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (!sys_rst) begin
      seen[rec_status] <= 1'b1;
    end
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    apb_req <= '0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Waits for the start pulse, then for the recorder to settle back to ready
  task wait_rec;
    int t;
    t = 0;
    while (rec_start !== 1'b1 && t < 500) begin
      @(posedge clk_sys);
      t++;
    end
    chk("rec_start", 32'h0000_0001, {31'h0, rec_start});
    // Status lags the state by a cycle, so it still shows ready here
    do begin
      @(posedge clk_sys);
      t++;
    end while (rec_status !== DRC_READY && t < 1000);
    repeat (4) @(posedge clk_sys);
  endtask : wait_rec

  task man_rec;
    wr(`DRC_OFS_CMD, 32'h0000_0001);
    if (ids.size() == 100) begin
      void'(ids.pop_front());
    end
    ids.push_back(nid);
    nid++;
    wait_rec();
  endtask : man_rec

  // Compares count and the whole ordered list of sequence ids with the model
  task mem;
    repeat (4) @(posedge clk_sys);
    rd(`DRC_OFS_STATUS);
    chk("status count", ids.size(), {25'h0, rv[14:8]});
    chk("stored_count", ids.size(), {25'h0, stored_count});
    foreach (ids[i]) begin
      wr(`DRC_OFS_RD_IDX, i);
      rd(`DRC_OFS_REC_ID);
      chk("record id", {16'h0000, ids[i]}, {16'h0000, rv[15:0]});
    end
  endtask : mem

  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`DRC_OFS_STATUS);
    chk("state after reset", DRC_BAD_CFG, {29'h0, rv[2:0]});
    chk("stored_count", 32'h0000_0000, {25'h0, stored_count});
    rd(8'h3C);
    chk("unmapped error", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, rv);
    $display("test reset done");

    for (int p = 0; p < 2; p++) begin
      chan_in <= (p == 0) ? 30'h2AAA_AAAA : 30'h1555_5555;
      repeat (SC + 6) @(posedge clk_sys);
      rd(`DRC_OFS_CHAN);
      chk("channels", {chan_in, 2'b10}, rv);
    end
    chan_in <= '0;
    repeat (SC + 6) @(posedge clk_sys);
    $display("test channels done");

    wr(`DRC_OFS_CTRL, 32'h0000_0000);
    wr(`DRC_OFS_CHAN_CFG, 32'h0000_0007);
    repeat (250) @(posedge clk_sys);
    rd(`DRC_OFS_MAX_LEN);
    chk("max length", 32'h0009_951A, rv);
    wr(`DRC_OFS_CTRL, 32'h0000_000C);
    wr(`DRC_OFS_CHAN_CFG, 32'h0000_001F);
    repeat (250) @(posedge clk_sys);
    rd(`DRC_OFS_MAX_LEN);
    chk("max length 8 s/c", 32'h0013_2A34, rv);
    wr(`DRC_OFS_CHAN_CFG, 32'h0000_0100);
    wr(`DRC_OFS_REC_LEN, 32'h0000_0005);
    wr(`DRC_OFS_PRE_LEN, 32'h0000_0000);
    wr(`DRC_OFS_TRIG_MASK, 32'h0000_0040);
    repeat (250) @(posedge clk_sys);
    rd(`DRC_OFS_MAX_LEN);
    chk("max length capped", `DRC_MAX_LEN_CAP, rv);
    rd(`DRC_OFS_MAX_NUM);
    chk("max number", 32'h0000_0064, rv);
    rd(`DRC_OFS_MAX_PRE);
    chk("max pretrigger", 32'h0000_0005, rv);
    $display("test derived values done");

    wr(`DRC_OFS_CMD, 32'h0000_0001);
    repeat (SC * 6) @(posedge clk_sys);
    chk("count while disabled", 32'h0000_0000, {25'h0, stored_count});
    wr(`DRC_OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge clk_sys);
    chk("state ready", DRC_READY, {29'h0, rec_status});
    for (int i = 0; i < 3; i++) begin
      man_rec();
      rd(`DRC_OFS_CMD);
      chk("manual cmd idle", 32'h0000_0000, {31'h0, rv[0]});
    end
    mem();
    $display("test manual trigger done");

    for (int k = 2; k < 32; k += 29) begin
      wr(`DRC_OFS_TRIG_MASK, 32'h0000_0001 << k);
      chan_in <= 30'h0000_0001 << (k - 2);
      ids.push_back(nid);
      nid++;
      wait_rec();
      chan_in <= '0;
      repeat (SC * 2 + 4) @(posedge clk_sys);
    end
    mem();
    $display("test auto trigger done");

    wr(`DRC_OFS_CMD, 32'h0000_0004);
    void'(ids.pop_back());
    mem();
    wr(`DRC_OFS_CMD, 32'h0000_0008);
    void'(ids.pop_front());
    mem();
    wr(`DRC_OFS_CLR_IDX, 32'h0000_0002);
    ids.delete(1);
    mem();
    wr(`DRC_OFS_CLR_IDX, ids.size() + 1);
    mem();
    wr(`DRC_OFS_CMD, 32'h0000_0002);
    ids.delete();
    mem();
    wr(`DRC_OFS_CMD, 32'h0000_0004);
    mem();
    $display("test clears done");

    for (int i = 0; i < 101; i++) begin
      man_rec();
    end
    mem();
    wr(`DRC_OFS_CTRL, 32'h0000_0003);
    repeat (6) @(posedge clk_sys);
    chk("state full", DRC_FULL, {29'h0, rec_status});
    wr(`DRC_OFS_CMD, 32'h0000_0001);
    repeat (SC * 6) @(posedge clk_sys);
    mem();
    chk("states seen", 32'h0000_005F, {24'h0, seen});
    $display("test memory full done");
    report_and_stop();
  end
endmodule : testbench
